// >>> hdl/usb_fifo_clock_recovery_control.sv
// usb endpoint fifo ram, indexed registers and clock recovery trim
// Operation
// - low select nibble picks indexed endpoint
// - speed bit chooses full or low speed
// - recovery trims oscillator from received frames
// - single step calibration moves trim by one
// - 1024 byte ram holds endpoint fifos
// - endpoints 1-3 in, out or split
// - split: upper half in, lower half out
// - unsplit fifo works one direction bit
// - double buffering only on endpoints 1-3
// - split allows separate in/out double buffering
// - enforce maximum packet sizes per configuration
// - each fifo access moves one byte
// - split reads drain out, writes fill in
// - fifo ports at addresses 0x20-0x23
`timescale 1ns/1ns
module usb_fifo_clock_recovery_control #(
    parameter int FRAME_CYCLES = usb_fifo_pkg::FRAME_CYCLES,
    parameter int CNT_W = usb_fifo_pkg::FRAME_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic xcvr_speed_full,
    output logic full_speed,
    input wire logic [1:0] usb_ep,
    input wire logic usb_out_push,
    input wire logic [7:0] usb_out_data,
    input wire logic usb_out_end,
    input wire logic usb_in_pop,
    output logic [7:0] usb_in_data,
    output logic usb_in_valid,
    input wire logic cpu_in_commit,
    input wire logic frame_mark,
    output logic [6:0] osc_trim
);
    localparam int NF = usb_fifo_pkg::NUM_FIFO;
    localparam int NE = usb_fifo_pkg::NUM_EP;
    localparam int AW = usb_fifo_pkg::RAM_AW;
    localparam int CW = usb_fifo_pkg::CNT_W;
    localparam logic [CNT_W-1:0] FRAME_TGT = CNT_W'(FRAME_CYCLES);

    logic [3:0] ep_select;
    logic rec_en;
    logic single_step;
    logic low_rec;
    logic [NE-1:0] split_mode;
    logic [NE-1:0] dir_in;
    logic [NE-1:0] dbl_in;
    logic [NE-1:0] dbl_out;
    logic [7:0] ram [usb_fifo_pkg::RAM_BYTES];
    logic [10:0] half [NE];
    logic [AW-1:0] base [NF];
    logic [CW-1:0] cap [NF];
    logic [CW-1:0] max_pkt [NF];
    logic [NF-1:0] en;
    logic [NF-1:0] push;
    logic [NF-1:0] pop;
    logic [NF-1:0] commit;
    logic [NF-1:0] flush;
    logic [NF-1:0] push_ok;
    logic [NF-1:0] pop_ok;
    logic [AW-1:0] wr_addr [NF];
    logic [AW-1:0] rd_addr [NF];
    logic [CW-1:0] count [NF];
    logic sel_ok;
    logic [1:0] sel_ep;
    logic cpu_fifo;
    logic [2:0] cpu_in_f;
    logic [2:0] cpu_out_f;
    logic [2:0] usb_in_f;
    logic [2:0] usb_out_f;
    logic [7:0] in_ctrl_rd;
    logic [7:0] out_ctrl_rd;

    assign sel_ok = ep_select < 4'(NE);
    assign sel_ep = ep_select[1:0];
    assign cpu_fifo = reg_addr[5:2] == usb_fifo_pkg::ADDR_FIFO_BASE[5:2];
    assign cpu_in_f = {reg_addr[1:0], 1'b1};
    assign cpu_out_f = {reg_addr[1:0], 1'b0};
    assign usb_in_f = {usb_ep, 1'b1};
    assign usb_out_f = {usb_ep, 1'b0};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ep_select <= usb_fifo_pkg::EP_SELECT_RESET;
        end else if (reg_wr && reg_addr == usb_fifo_pkg::ADDR_EP_SELECT) begin
            ep_select <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {rec_en, single_step, low_rec} <= usb_fifo_pkg::CLK_REC_RESET;
        end else if (reg_wr && reg_addr == usb_fifo_pkg::ADDR_CLK_REC) begin
            rec_en <= reg_wdata[usb_fifo_pkg::REC_ENABLE_POS];
            single_step <= reg_wdata[usb_fifo_pkg::SINGLE_STEP_POS];
            low_rec <= reg_wdata[usb_fifo_pkg::LOW_SPEED_REC_POS];
        end
    end

    // endpoint 0 keeps no split or double buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            split_mode <= '0;
            dir_in <= '0;
            dbl_in <= '0;
            dbl_out <= '0;
        end else if (reg_wr && sel_ok && sel_ep != 2'h0) begin
            if (reg_addr == usb_fifo_pkg::ADDR_IN_CTRL_HIGH) begin
                split_mode[sel_ep] <= reg_wdata[usb_fifo_pkg::SPLIT_POS];
                dir_in[sel_ep] <= reg_wdata[usb_fifo_pkg::DIR_POS];
                dbl_in[sel_ep] <= reg_wdata[usb_fifo_pkg::IN_DBL_POS];
            end
            if (reg_addr == usb_fifo_pkg::ADDR_OUT_CTRL_HIGH) begin
                dbl_out[sel_ep] <= reg_wdata[usb_fifo_pkg::OUT_DBL_POS];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            full_speed <= 1'b0;
        end else begin
            full_speed <= xcvr_speed_full;
        end
    end

    // region layout for each endpoint pair
    always_comb begin
        for (int e = 0; e < NE; e++) begin
            half[e] = split_mode[e] ? usb_fifo_pkg::EP_SIZE[e] >> 1 : usb_fifo_pkg::EP_SIZE[e];
            base[2*e] = usb_fifo_pkg::EP_BASE[e];
            base[2*e+1] = split_mode[e] ? usb_fifo_pkg::EP_BASE[e] + half[e][AW-1:0]
                                        : usb_fifo_pkg::EP_BASE[e];
            cap[2*e] = half[e];
            cap[2*e+1] = half[e];
            // out half follows its own bit only when split
            max_pkt[2*e] = (split_mode[e] ? dbl_out[e] : dbl_in[e]) ? half[e] >> 1 : half[e];
            max_pkt[2*e+1] = dbl_in[e] ? half[e] >> 1 : half[e];
            en[2*e] = (e == 0) || split_mode[e] || !dir_in[e];
            en[2*e+1] = (e == 0) || split_mode[e] || dir_in[e];
        end
    end

    // cpu reads drain out, writes fill in
    always_comb begin
        push = '0;
        pop = '0;
        commit = '0;
        flush = '0;
        push[cpu_in_f] = reg_wr && cpu_fifo && en[cpu_in_f];
        pop[cpu_out_f] = reg_rd && cpu_fifo && en[cpu_out_f];
        push[usb_out_f] = usb_out_push && en[usb_out_f];
        pop[usb_in_f] = usb_in_pop && en[usb_in_f];
        commit[usb_out_f] = usb_out_end;
        commit[{sel_ep, 1'b1}] = cpu_in_commit && sel_ok;
        if (reg_wr && sel_ok && sel_ep != 2'h0 && reg_addr == usb_fifo_pkg::ADDR_IN_CTRL_HIGH) begin
            flush[{sel_ep, 1'b0}] = 1'b1;
            flush[{sel_ep, 1'b1}] = 1'b1;
        end
    end

    for (genvar f = 0; f < NF; f++) begin : g_fifo
        ep_fifo_ctrl #(.AW(AW), .CW(CW)) u_ctrl (
            .clk(clk),
            .rst_n(rst_n),
            .base(base[f]),
            .cap(cap[f]),
            .max_pkt(max_pkt[f]),
            .push(push[f]),
            .pop(pop[f]),
            .commit(commit[f]),
            .flush(flush[f]),
            .push_ok(push_ok[f]),
            .pop_ok(pop_ok[f]),
            .wr_addr(wr_addr[f]),
            .rd_addr(rd_addr[f]),
            .count(count[f])
        );
    end

    always_ff @(posedge clk) begin
        if (push_ok[cpu_in_f]) begin
            ram[wr_addr[cpu_in_f]] <= reg_wdata;
        end
        if (push_ok[usb_out_f]) begin
            ram[wr_addr[usb_out_f]] <= usb_out_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usb_in_data <= 8'h00;
            usb_in_valid <= 1'b0;
        end else begin
            usb_in_valid <= pop_ok[usb_in_f];
            usb_in_data <= pop_ok[usb_in_f] ? ram[rd_addr[usb_in_f]] : 8'h00;
        end
    end

    always_comb begin
        in_ctrl_rd = 8'h00;
        out_ctrl_rd = 8'h00;
        in_ctrl_rd[usb_fifo_pkg::SPLIT_POS] = split_mode[sel_ep];
        in_ctrl_rd[usb_fifo_pkg::DIR_POS] = dir_in[sel_ep];
        in_ctrl_rd[usb_fifo_pkg::IN_DBL_POS] = dbl_in[sel_ep];
        out_ctrl_rd[usb_fifo_pkg::OUT_DBL_POS] = dbl_out[sel_ep];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (cpu_fifo) begin
                reg_rdata <= pop_ok[cpu_out_f] ? ram[rd_addr[cpu_out_f]] : 8'h00;
            end else begin
                case (reg_addr)
                    usb_fifo_pkg::ADDR_EP_SELECT: reg_rdata <= {4'h0, ep_select};
                    usb_fifo_pkg::ADDR_CLK_REC: reg_rdata <= {rec_en, single_step, low_rec, 5'h00};
                    usb_fifo_pkg::ADDR_IN_CTRL_HIGH: reg_rdata <= sel_ok ? in_ctrl_rd : 8'h00;
                    usb_fifo_pkg::ADDR_OUT_CTRL_HIGH: reg_rdata <= sel_ok ? out_ctrl_rd : 8'h00;
                    usb_fifo_pkg::ADDR_OUT_COUNT_LOW: begin
                        reg_rdata <= sel_ok ? count[{sel_ep, 1'b0}][7:0] : 8'h00;
                    end
                    usb_fifo_pkg::ADDR_OUT_COUNT_HIGH: begin
                        reg_rdata <= sel_ok ? {5'h00, count[{sel_ep, 1'b0}][10:8]} : 8'h00;
                    end
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // clock recovery: frame length measured in local cycles
    usb_fifo_pkg::rec_state_t rec_state;
    logic [CNT_W-1:0] frame_cnt;
    logic [CNT_W-1:0] meas;
    logic [CNT_W-1:0] diff;
    logic [CNT_W-1:0] shifted;
    logic [6:0] step;
    logic slow;
    logic [6:0] next_trim;

    always_comb begin
        meas = frame_cnt + 1'b1;
        slow = meas < FRAME_TGT;
        diff = slow ? FRAME_TGT - meas : meas - FRAME_TGT;
        shifted = low_rec ? diff >> usb_fifo_pkg::TRIM_SHIFT_LOW : diff >> usb_fifo_pkg::TRIM_SHIFT;
        if (single_step || shifted == '0) begin
            step = usb_fifo_pkg::TRIM_STEP_ONE;
        end else if (shifted > CNT_W'(usb_fifo_pkg::TRIM_STEP_MAX)) begin
            step = usb_fifo_pkg::TRIM_STEP_MAX;
        end else begin
            step = shifted[6:0];
        end
        if (diff == '0) begin
            next_trim = osc_trim;
        end else if (slow) begin
            next_trim = (usb_fifo_pkg::TRIM_MAX - osc_trim < step) ? usb_fifo_pkg::TRIM_MAX
                                                                   : osc_trim + step;
        end else begin
            next_trim = (osc_trim < step) ? 7'h00 : osc_trim - step;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_state <= usb_fifo_pkg::REC_IDLE;
        end else begin
            case (rec_state)
                usb_fifo_pkg::REC_IDLE: begin
                    if (rec_en && frame_mark) begin
                        rec_state <= usb_fifo_pkg::REC_TRACK;
                    end
                end
                usb_fifo_pkg::REC_TRACK: begin
                    if (!rec_en) begin
                        rec_state <= usb_fifo_pkg::REC_IDLE;
                    end
                end
                default: rec_state <= usb_fifo_pkg::REC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt <= '0;
        end else if (frame_mark) begin
            frame_cnt <= '0;
        end else if (frame_cnt != '1) begin
            frame_cnt <= frame_cnt + 1'b1;
        end
    end

    // trim update on each frame while tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_trim <= usb_fifo_pkg::TRIM_RESET;
        end else if (rec_en && frame_mark && rec_state == usb_fifo_pkg::REC_TRACK) begin
            osc_trim <= next_trim;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sel_write_a: assert property (reg_wr && reg_addr == usb_fifo_pkg::ADDR_EP_SELECT |=> ep_select == $past(reg_wdata[3:0]))
        else $error("endpoint select not stored");
    speed_follow_a: assert property (full_speed == $past(xcvr_speed_full, 1) || $past(!rst_n))
        else $error("speed output does not follow speed bit");
    split_route_a: assert property (reg_rd && cpu_fifo && split_mode[reg_addr[1:0]] |-> !pop[cpu_in_f] && pop[cpu_out_f])
        else $error("split read did not drain out half");
    dir_block_a: assert property (usb_out_push && usb_ep != 2'h0 && !split_mode[usb_ep] && dir_in[usb_ep] |-> !push_ok[usb_out_f])
        else $error("unsplit fifo took the unselected direction");
    split_base_a: assert property (split_mode[3] |-> base[7] == usb_fifo_pkg::EP_BASE[3] + 10'h100)
        else $error("split in half not in upper half");
    ep0_size_a: assert property (max_pkt[0] == 11'h040 && max_pkt[1] == 11'h040)
        else $error("endpoint 0 packet size wrong");
    dbl_half_a: assert property (dbl_in[2] |-> max_pkt[5] == cap[5] >> 1)
        else $error("double buffer did not halve packet size");
    trim_single_a: assert property (single_step && $past(single_step) && osc_trim != $past(osc_trim) |-> (osc_trim - $past(osc_trim) == 7'h01) || ($past(osc_trim) - osc_trim == 7'h01))
        else $error("single step moved trim by more than one");
    rec_off_a: assert property (!rec_en |=> $stable(osc_trim))
        else $error("trim changed with recovery disabled");
    in_read_a: assert property (usb_in_pop && pop_ok[usb_in_f] |=> usb_in_valid)
        else $error("accepted in pop gave no byte");

    split_read_c: cover property (reg_rd && cpu_fifo && reg_addr[1:0] == 2'h3 && split_mode[3] && pop_ok[6]);
    trim_move_c: cover property (rec_en && frame_mark && rec_state == usb_fifo_pkg::REC_TRACK && next_trim != osc_trim);
    fifo_full_c: cover property (push[3] && !push_ok[3] && count[3] == cap[3]);
    dbl_pkt_c: cover property (dbl_in[1] && push[3] && !push_ok[3]);
endmodule : usb_fifo_clock_recovery_control

// >>> hdl/usb_fifo_pkg.sv
// constants for the usb endpoint fifo and clock recovery block
package usb_fifo_pkg;
    localparam int REG_AW = 6;
    localparam logic [5:0] ADDR_EP_SELECT = 6'h0E;
    localparam logic [5:0] ADDR_CLK_REC = 6'h0F;
    localparam logic [5:0] ADDR_IN_CTRL_HIGH = 6'h12;
    localparam logic [5:0] ADDR_OUT_CTRL_HIGH = 6'h15;
    localparam logic [5:0] ADDR_OUT_COUNT_LOW = 6'h16;
    localparam logic [5:0] ADDR_OUT_COUNT_HIGH = 6'h17;
    localparam logic [5:0] ADDR_FIFO_BASE = 6'h20;
    localparam int NUM_EP = 4;
    localparam int NUM_FIFO = 8;
    localparam logic [3:0] EP_SELECT_RESET = 4'h0;
    localparam logic [2:0] CLK_REC_RESET = 3'h0;
    // clock recovery control fields
    localparam int REC_ENABLE_POS = 7;
    localparam int SINGLE_STEP_POS = 6;
    localparam int LOW_SPEED_REC_POS = 5;
    // in/out control high fields
    localparam int IN_DBL_POS = 7;
    localparam int DIR_POS = 3;
    localparam int SPLIT_POS = 2;
    localparam int OUT_DBL_POS = 7;
    // fifo ram layout, byte offsets inside the 1024 byte ram
    localparam int RAM_BYTES = 1024;
    localparam int RAM_AW = 10;
    localparam int CNT_W = 11;
    localparam logic [9:0] EP_BASE [NUM_EP] = '{10'h000, 10'h340, 10'h240, 10'h040};
    localparam logic [10:0] EP_SIZE [NUM_EP] = '{11'h040, 11'h080, 11'h100, 11'h200};
    // frame period used by clock recovery
    localparam int FRAME_NS = 1000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;
    localparam int FRAME_CNT_W = 20;
    localparam int TRIM_W = 7;
    localparam logic [6:0] TRIM_RESET = 7'h40;
    localparam logic [6:0] TRIM_MAX = 7'h7F;
    localparam logic [6:0] TRIM_STEP_ONE = 7'h01;
    localparam logic [6:0] TRIM_STEP_MAX = 7'h08;
    localparam int TRIM_SHIFT = 4;
    localparam int TRIM_SHIFT_LOW = 6;
    typedef enum logic [0:0] {REC_IDLE, REC_TRACK} rec_state_t;
endpackage : usb_fifo_pkg

// >>> hdl/ep_fifo_ctrl.sv
// pointer and count keeping for one endpoint fifo region
`timescale 1ns/1ns
module ep_fifo_ctrl #(
    parameter int AW = 10,
    parameter int CW = 11
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] base,
    input wire logic [CW-1:0] cap,
    input wire logic [CW-1:0] max_pkt,
    input wire logic push,
    input wire logic pop,
    input wire logic commit,
    input wire logic flush,
    output logic push_ok,
    output logic pop_ok,
    output logic [AW-1:0] wr_addr,
    output logic [AW-1:0] rd_addr,
    output logic [CW-1:0] count
);
    logic [CW-1:0] wr_off;
    logic [CW-1:0] rd_off;
    logic [CW-1:0] pkt_cnt;

    assign push_ok = push && (count < cap) && (pkt_cnt < max_pkt);
    assign pop_ok = pop && (count != '0);
    assign wr_addr = AW'(base + wr_off);
    assign rd_addr = AW'(base + rd_off);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (flush) begin
            count <= '0;
        end else if (push_ok && !pop_ok) begin
            count <= count + 1'b1;
        end else if (pop_ok && !push_ok) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_off <= '0;
            rd_off <= '0;
        end else if (flush) begin
            wr_off <= '0;
            rd_off <= '0;
        end else begin
            if (push_ok) begin
                wr_off <= (wr_off + 1'b1 == cap) ? '0 : wr_off + 1'b1;
            end
            if (pop_ok) begin
                rd_off <= (rd_off + 1'b1 == cap) ? '0 : rd_off + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_cnt <= '0;
        end else if (flush || commit) begin
            pkt_cnt <= '0;
        end else if (push_ok) begin
            pkt_cnt <= pkt_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    fifo_push_a: assert property (push_ok && !pop_ok && !flush |=> count == $past(count) + 1'b1)
        else $error("accepted push did not add one byte");
    fifo_pop_a: assert property (pop_ok && !push_ok && !flush |=> count == $past(count) - 1'b1)
        else $error("accepted pop did not remove one byte");
    fifo_cap_a: assert property (count <= cap)
        else $error("fifo count above region size");
    pkt_limit_a: assert property (push && pkt_cnt >= max_pkt |-> !push_ok)
        else $error("byte accepted beyond packet size");
endmodule : ep_fifo_ctrl

// >>> tb/usb_engine_model.sv
// usb engine and frame marker model facing the fifo block
`timescale 1ns/1ns
module usb_engine_model (
    input wire logic clk,
    output logic [1:0] usb_ep,
    output logic usb_out_push,
    output logic [7:0] usb_out_data,
    output logic usb_out_end,
    output logic usb_in_pop,
    input wire logic [7:0] usb_in_data,
    input wire logic usb_in_valid,
    output logic frame_mark
);
    initial begin
        usb_ep = 2'h0;
        usb_out_push = 1'b0;
        usb_out_data = 8'h00;
        usb_out_end = 1'b0;
        usb_in_pop = 1'b0;
        frame_mark = 1'b0;
    end
    task automatic push_byte(input logic [1:0] ep, input logic [7:0] d);
        @(posedge clk);
        usb_ep <= ep;
        usb_out_data <= d;
        usb_out_push <= 1'b1;
        @(posedge clk);
        usb_out_push <= 1'b0;
        // released data line shows the inverse
        usb_out_data <= ~d;
    endtask : push_byte
    task automatic end_packet(input logic [1:0] ep);
        @(posedge clk);
        usb_ep <= ep;
        usb_out_end <= 1'b1;
        @(posedge clk);
        usb_out_end <= 1'b0;
    endtask : end_packet
    task automatic pop_byte(input logic [1:0] ep, output logic v, output logic [7:0] d);
        @(posedge clk);
        usb_ep <= ep;
        usb_in_pop <= 1'b1;
        @(posedge clk);
        usb_in_pop <= 1'b0;
        #1;
        v = usb_in_valid;
        d = usb_in_data;
    endtask : pop_byte
    task automatic mark();
        @(posedge clk);
        frame_mark <= 1'b1;
        @(posedge clk);
        frame_mark <= 1'b0;
    endtask : mark
endmodule : usb_engine_model

// >>> tb/usb_endpoint_fifo_and_clock_recovery_tb_top.sv
// self-checking bench for the usb fifo and clock recovery block
`timescale 1ns/1ns
module usb_endpoint_fifo_and_clock_recovery_tb_top;
    logic clk, rst_n, reg_wr, reg_rd, xcvr_speed_full, full_speed, usb_out_push;
    logic usb_out_end, usb_in_pop, usb_in_valid, cpu_in_commit, frame_mark;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, usb_out_data, usb_in_data, rd, pd;
    logic [1:0] usb_ep;
    logic [6:0] osc_trim;
    logic pv;
    int num_errors;
    int checked;
    usb_fifo_clock_recovery_control #(.FRAME_CYCLES(200), .CNT_W(20)) DUT (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .xcvr_speed_full(xcvr_speed_full), .full_speed(full_speed),
        .usb_ep(usb_ep), .usb_out_push(usb_out_push), .usb_out_data(usb_out_data),
        .usb_out_end(usb_out_end), .usb_in_pop(usb_in_pop), .usb_in_data(usb_in_data),
        .usb_in_valid(usb_in_valid), .cpu_in_commit(cpu_in_commit),
        .frame_mark(frame_mark), .osc_trim(osc_trim));
    usb_engine_model eng (.clk(clk), .usb_ep(usb_ep), .usb_out_push(usb_out_push),
        .usb_out_data(usb_out_data), .usb_out_end(usb_out_end), .usb_in_pop(usb_in_pop),
        .usb_in_data(usb_in_data), .usb_in_valid(usb_in_valid), .frame_mark(frame_mark));
    // bench clock stands in for the usb clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    task automatic test_select();
        reg_write(6'h0E, 8'hFF);
        reg_read(6'h0E, rd);
        check("select", 16'h000F, {8'h00, rd});
        reg_write(6'h0E, 8'h04);
        reg_read(6'h12, rd);
        check("reserved index read", 16'h0000, {8'h00, rd});
        reg_read(6'h30, rd);
        check("unmapped read", 16'h0000, {8'h00, rd});
        @(posedge clk);
        xcvr_speed_full <= 1'b1;
        repeat (3) @(posedge clk);
        check("full speed", 16'h0001, {15'h0000, full_speed});
        xcvr_speed_full <= 1'b0;
        repeat (3) @(posedge clk);
        check("low speed", 16'h0000, {15'h0000, full_speed});
        $display("test_select done");
    endtask : test_select
    task automatic test_split_ep3();
        reg_write(6'h0E, 8'h03);
        reg_write(6'h12, 8'h04);
        eng.push_byte(2'h3, 8'h5A);
        eng.push_byte(2'h3, 8'hA5);
        eng.end_packet(2'h3);
        reg_write(6'h23, 8'h77);
        reg_read(6'h16, rd);
        check("out count", 16'h0002, {8'h00, rd});
        reg_read(6'h23, rd);
        check("out byte", 16'h005A, {8'h00, rd});
        reg_read(6'h16, rd);
        check("out count", 16'h0001, {8'h00, rd});
        reg_read(6'h23, rd);
        check("out byte", 16'h00A5, {8'h00, rd});
        reg_read(6'h23, rd);
        check("empty read", 16'h0000, {8'h00, rd});
        eng.pop_byte(2'h3, pv, pd);
        check("in byte", 16'h0177, {7'h00, pv, pd});
        $display("test_split_ep3 done");
    endtask : test_split_ep3
    task automatic test_sizes();
        logic [1:0] eps [8] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
        logic [7:0] cfg [8] = '{8'h80, 8'h04, 8'h84, 8'h08, 8'h00, 8'h04, 8'h88, 8'h84};
        int lim [8] = '{64, 64, 32, 128, 0, 128, 256, 64};
        logic [15:0] got;
        for (int c = 0; c < 8; c++) begin
            got = 16'h0000;
            reg_write(6'h0E, {6'h00, eps[c]});
            reg_write(6'h12, cfg[c]);
            if (c == 3) begin
                eng.push_byte(2'h1, 8'hC3);
                reg_read(6'h16, rd);
                check("blocked out", 16'h0000, {8'h00, rd});
            end
            for (int i = 0; i <= lim[c]; i++) reg_write(6'h20 + {4'h0, eps[c]}, 8'(i));
            for (int i = 0; i <= lim[c]; i++) begin
                eng.pop_byte(eps[c], pv, pd);
                if (pv === 1'b1) begin
                    check("fifo byte", {8'h00, 8'(got)}, {8'h00, pd});
                    got++;
                end
            end
            check("packet bytes", 16'(lim[c]), got);
        end
        $display("test_sizes done");
    endtask : test_sizes
    task automatic test_double_out();
        int n;
        n = 0;
        reg_write(6'h0E, 8'h01);
        reg_write(6'h12, 8'h84);
        reg_write(6'h15, 8'h80);
        reg_read(6'h12, rd);
        check("in ctrl", 16'h0084, {8'h00, rd});
        reg_read(6'h15, rd);
        check("out ctrl", 16'h0080, {8'h00, rd});
        for (int i = 0; i <= 32; i++) eng.push_byte(2'h1, 8'(i));
        reg_read(6'h16, rd);
        check("out double count", 16'h0020, {8'h00, rd});
        reg_read(6'h17, rd);
        check("out count high", 16'h0000, {8'h00, rd});
        for (int i = 0; i <= 32; i++) reg_write(6'h21, 8'(i));
        @(posedge clk);
        cpu_in_commit <= 1'b1;
        @(posedge clk);
        cpu_in_commit <= 1'b0;
        reg_write(6'h21, 8'hEE);
        for (int i = 0; i <= 33; i++) begin
            eng.pop_byte(2'h1, pv, pd);
            if (pv === 1'b1) n++;
        end
        check("in after commit", 16'h0021, 16'(n));
        $display("test_double_out done");
    endtask : test_double_out
    task automatic test_recovery();
        logic [7:0] cfg [4] = '{8'h80, 8'h80, 8'hC0, 8'hA0};
        int gap [4] = '{100, 300, 100, 100};
        int step;
        logic [6:0] exp_trim;
        exp_trim = 7'h40;
        reg_write(6'h0F, 8'hFF);
        reg_read(6'h0F, rd);
        check("recovery reg", 16'h00E0, {8'h00, rd});
        for (int c = 0; c < 4; c++) begin
            reg_write(6'h0F, 8'h00);
            reg_write(6'h0F, cfg[c]);
            eng.mark();
            repeat (gap[c] - 2) @(posedge clk);
            eng.mark();
            repeat (2) @(posedge clk);
            #1;
            step = (cfg[c][5] ? 100 >> 6 : 100 >> 4);
            if (cfg[c][6]) step = 1;
            if (gap[c] < 200) exp_trim = exp_trim + 7'(step);
            else exp_trim = exp_trim - 7'(step);
            check("osc trim", {9'h000, exp_trim}, {9'h000, osc_trim});
        end
        reg_write(6'h0F, 8'h00);
        eng.mark();
        repeat (98) @(posedge clk);
        eng.mark();
        repeat (2) @(posedge clk);
        #1;
        check("frozen trim", {9'h000, exp_trim}, {9'h000, osc_trim});
        $display("test_recovery done");
    endtask : test_recovery
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        num_errors = 0;
        checked = 0;
        rst_n = 1'b0;
        reg_addr = 6'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        xcvr_speed_full = 1'b0;
        cpu_in_commit = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("reset trim", 16'h0040, {9'h000, osc_trim});
        reg_read(6'h0E, rd);
        check("reset select", 16'h0000, {8'h00, rd});
        reg_read(6'h0F, rd);
        check("reset recovery", 16'h0000, {8'h00, rd});
        $display("test_reset done");
        test_select();
        test_split_ep3();
        test_sizes();
        test_double_out();
        test_recovery();
        finish_test();
    end
endmodule : usb_endpoint_fifo_and_clock_recovery_tb_top
